// file: src/dd_cdb.sv
`default_nettype none

module dd_cdb #(
  parameter int N = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_byte
);

  logic [7:0] mem [N];

  // ----------------------------------------
  // Command block store, four bytes from the low word, the rest from the high word
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if ((i < 4 && wr_lo) || (i >= 4 && wr_hi)) begin
          mem[i] <= wdata[(i % 4) * 8 +: 8];
        end
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (int'(rd_idx) < N) begin
      rd_byte = mem[rd_idx];
    end
  end

endmodule

`default_nettype wire

// file: src/dd_cfg.svh
`ifndef DD_CFG_SVH
`define DD_CFG_SVH

// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define DD_OFS_CTRL    8'h00
`define DD_OFS_ADDR    8'h04
`define DD_OFS_COUNT   8'h08
`define DD_OFS_FCMD    8'h0C
`define DD_OFS_CDB_LO  8'h10
`define DD_OFS_CDB_HI  8'h14
`define DD_OFS_STATUS  8'h18
`define DD_OFS_LEN     8'h1C

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define DD_CTRL_START  0
`define DD_CTRL_DIR    1
`define DD_CTRL_HD     2
`define DD_CTRL_DRIVE  3
`define DD_CTRL_SIDE   4
`define DD_CTRL_TRACK  5
`define DD_ST_BUSY     0
`define DD_ST_DONE     1
`define DD_ST_ECC      2

// ----------------------------------------
// Device register indices and mode word
// ----------------------------------------
`define DD_DEV_DATA    3'h0
`define DD_DEV_MODE    3'h1
`define DD_DEV_BASE_HI 3'h2
`define DD_DEV_BASE_MI 3'h3
`define DD_DEV_BASE_LO 3'h4
`define DD_DEV_STATUS  3'h5
`define DD_MODE_FLAG   1
`define DD_MODE_CMD    3
`define DD_MODE_SCNT   4
`define DD_MODE_HD     7
`define DD_MODE_DIR    8

// ----------------------------------------
// Command block
// ----------------------------------------
`define DD_CDB_LEN     6
`define DD_SECT_BYTES  512
`define DD_SECT_SHIFT  9
`define DD_OP_TEST     8'h00
`define DD_OP_VERIFY   8'h05
`define DD_OP_FORMAT   8'h06
`define DD_OP_READ     8'h08
`define DD_OP_WRITE    8'h0A
`define DD_OP_SEEK     8'h0B
`define DD_OP_CORR     8'h0D
`define DD_OP_MSEL     8'h15
`define DD_OP_MSENSE   8'h1A

// ----------------------------------------
// Timing
// ----------------------------------------
`define DD_CLK_MHZ     100
`define DD_STROBE_NS   60
`define DD_STROBE_CYC  ((`DD_STROBE_NS * `DD_CLK_MHZ + 999) / 1000)
`define DD_SETTLE_CYC  4

`endif

// file: src/dd_host.sv
// The address map and the APB interface to the registers were chosen for this implementation.
`include "dd_cfg.svh"
`default_nettype none

module dd_host import dd_pkg::*; #(
  parameter int CDB_LEN = `DD_CDB_LEN,
  parameter int STROBE_CYC = `DD_STROBE_CYC,
  parameter int SETTLE_CYC = `DD_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] dev_addr,
  output logic [15:0] dev_wdata,
  output logic dev_cs_n,
  output logic dev_read,
  input wire logic [7:0] dev_rdata,
  input wire logic dev_active,
  output logic gpo_side_sel,
  output logic gpo_drive0_sel_n,
  output logic gpo_drive1_sel_n
);

  dd_state_t state_reg;
  logic ctl_dir_reg, ctl_hd_reg, ctl_drive_reg, ctl_side_reg, ctl_track_reg;
  logic [23:0] addr_reg;
  logic [7:0] count_reg, fcmd_reg, fint_reg;
  logic [7:0] dma_stat_reg, hd_stat_reg;
  logic done_reg, ecc_reg;
  logic [7:0] cdb_op_reg;
  logic acc_on_reg;
  logic [7:0] acc_cnt_reg;
  logic [2:0] cdb_idx_reg;
  logic [7:0] settle_reg;
  logic [7:0] active_rdata;
  logic active_s;
  logic [7:0] cdb_byte;
  logic apb_setup, apb_wr, start_req, done_clr;
  logic busy;
  logic acc_state;
  logic [2:0] acc_addr;
  logic [15:0] acc_data;
  logic acc_read;
  dd_state_t acc_next;
  logic [15:0] mode_base;
  logic [31:0] rd_val;
  logic rd_ok;

  // ----------------------------------------
  // Pin inputs through two flops
  // ----------------------------------------
  dd_sync #(.W(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({dev_active, dev_rdata}),
    .q({active_s, active_rdata})
  );

  // ----------------------------------------
  // Command block store
  // ----------------------------------------
  dd_cdb #(.N(CDB_LEN)) u_cdb (
    .pclk(pclk),
    .presetn(presetn),
    .wr_lo(apb_wr && paddr == `DD_OFS_CDB_LO),
    .wr_hi(apb_wr && paddr == `DD_OFS_CDB_HI),
    .wdata(pwdata),
    .rd_idx(cdb_idx_reg),
    .rd_byte(cdb_byte)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;
  assign busy = state_reg != DD_IDLE;
  assign start_req = apb_wr && paddr == `DD_OFS_CTRL &&
                     pwdata[`DD_CTRL_START] && !busy;
  assign done_clr = (apb_wr && paddr == `DD_OFS_STATUS &&
                     pwdata[`DD_ST_DONE]) || start_req;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (paddr == `DD_OFS_CTRL) begin
      rd_val[`DD_CTRL_DIR] = ctl_dir_reg;
      rd_val[`DD_CTRL_HD] = ctl_hd_reg;
      rd_val[`DD_CTRL_DRIVE] = ctl_drive_reg;
      rd_val[`DD_CTRL_SIDE] = ctl_side_reg;
      rd_val[`DD_CTRL_TRACK] = ctl_track_reg;
    end else if (paddr == `DD_OFS_ADDR) begin
      rd_val[23:0] = addr_reg;
    end else if (paddr == `DD_OFS_COUNT) begin
      rd_val[7:0] = count_reg;
    end else if (paddr == `DD_OFS_FCMD) begin
      rd_val[15:0] = {fint_reg, fcmd_reg};
    end else if (paddr == `DD_OFS_CDB_LO || paddr == `DD_OFS_CDB_HI) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `DD_OFS_STATUS) begin
      // No media change bit: removal is not visible here
      rd_val[`DD_ST_BUSY] = busy;
      rd_val[`DD_ST_DONE] = done_reg;
      rd_val[`DD_ST_ECC] = ecc_reg;
      rd_val[15:8] = dma_stat_reg;
      rd_val[23:16] = hd_stat_reg;
    end else if (paddr == `DD_OFS_LEN) begin
      rd_val = {15'h0000, count_reg, 9'h000};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // No wait state: every answer comes from a flop loaded during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !rd_ok;
      if (apb_setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // Configuration other than the command block store is frozen while a job runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_dir_reg <= 1'b0;
      ctl_hd_reg <= 1'b0;
      ctl_drive_reg <= 1'b0;
      ctl_side_reg <= 1'b0;
      ctl_track_reg <= 1'b0;
      addr_reg <= 24'h00_0000;
      count_reg <= 8'h00;
      fcmd_reg <= 8'h00;
      fint_reg <= 8'h00;
    end else if (apb_wr && !busy) begin
      if (paddr == `DD_OFS_CTRL) begin
        ctl_dir_reg <= pwdata[`DD_CTRL_DIR];
        ctl_hd_reg <= pwdata[`DD_CTRL_HD];
        ctl_drive_reg <= pwdata[`DD_CTRL_DRIVE];
        ctl_side_reg <= pwdata[`DD_CTRL_SIDE];
        ctl_track_reg <= pwdata[`DD_CTRL_TRACK];
      end else if (paddr == `DD_OFS_ADDR) begin
        addr_reg <= pwdata[23:0];
      end else if (paddr == `DD_OFS_COUNT) begin
        count_reg <= pwdata[7:0];
      end else if (paddr == `DD_OFS_FCMD) begin
        fcmd_reg <= pwdata[7:0];
        fint_reg <= pwdata[15:8];
      end
    end
  end

  // ----------------------------------------
  // Device access plan per state
  // ----------------------------------------
  always_comb begin
    mode_base = 16'h0000;
    mode_base[`DD_MODE_DIR] = ctl_dir_reg;
    mode_base[`DD_MODE_HD] = ctl_hd_reg;
    acc_state = 1'b1;
    acc_addr = `DD_DEV_MODE;
    acc_data = mode_base;
    acc_read = 1'b0;
    acc_next = DD_IDLE;
    case (state_reg)
      DD_BLO: begin
        acc_addr = `DD_DEV_BASE_LO;
        acc_data = {8'h00, addr_reg[7:0]};
        acc_next = DD_BMI;
      end
      DD_BMI: begin
        acc_addr = `DD_DEV_BASE_MI;
        acc_data = {8'h00, addr_reg[15:8]};
        acc_next = DD_BHI;
      end
      DD_BHI: begin
        acc_addr = `DD_DEV_BASE_HI;
        acc_data = {8'h00, addr_reg[23:16]};
        acc_next = DD_TOG;
      end
      DD_TOG: begin
        acc_data[`DD_MODE_DIR] = !ctl_dir_reg;
        acc_next = DD_DIR;
      end
      DD_DIR: begin
        acc_next = DD_SCNT;
      end
      DD_SCNT: begin
        acc_data[`DD_MODE_SCNT] = 1'b1;
        acc_next = DD_LCNT;
      end
      DD_LCNT: begin
        acc_addr = `DD_DEV_DATA;
        acc_data = {8'h00, count_reg};
        acc_next = DD_SCMD;
      end
      DD_SCMD: begin
        // Flag stays low so the first block byte selects a controller
        acc_data[`DD_MODE_CMD] = 1'b1;
        acc_next = ctl_hd_reg ? DD_HB : DD_FCMD;
      end
      DD_FCMD: begin
        acc_addr = `DD_DEV_DATA;
        acc_data = {8'h00, fcmd_reg};
        acc_next = DD_WAIT;
      end
      DD_HB: begin
        acc_addr = `DD_DEV_DATA;
        acc_data = {8'h00, cdb_byte};
        if (cdb_idx_reg == 3'(CDB_LEN - 1)) begin
          acc_next = DD_REL;
        end else if (cdb_idx_reg == 3'h0) begin
          acc_next = DD_FLAG;
        end else begin
          acc_next = DD_HB;
        end
      end
      DD_FLAG: begin
        acc_data[`DD_MODE_CMD] = 1'b1;
        acc_data[`DD_MODE_FLAG] = 1'b1;
        acc_next = DD_HB;
      end
      DD_REL: begin
        acc_next = DD_WAIT;
      end
      DD_FINT: begin
        acc_addr = `DD_DEV_DATA;
        acc_data = {8'h00, fint_reg};
        acc_next = DD_STAT;
      end
      DD_HSTAT: begin
        acc_addr = `DD_DEV_DATA;
        acc_read = 1'b1;
        acc_next = DD_STAT;
      end
      DD_STAT: begin
        acc_addr = `DD_DEV_STATUS;
        acc_read = 1'b1;
        acc_next = DD_DONE;
      end
      default: begin
        acc_state = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DD_IDLE;
      acc_on_reg <= 1'b0;
      acc_cnt_reg <= 8'h00;
      cdb_idx_reg <= 3'h0;
      settle_reg <= 8'h00;
      dev_addr <= `DD_DEV_DATA;
      dev_wdata <= 16'h0000;
      dev_cs_n <= 1'b1;
      dev_read <= 1'b0;
    end else if (acc_state) begin
      // Strobe held a fixed time; read data settles through the sync
      if (!acc_on_reg) begin
        dev_addr <= acc_addr;
        dev_wdata <= acc_read ? 16'h0000 : acc_data;
        dev_read <= acc_read;
        dev_cs_n <= 1'b0;
        acc_on_reg <= 1'b1;
        acc_cnt_reg <= 8'h00;
      end else if (acc_cnt_reg == 8'(STROBE_CYC + 2)) begin
        dev_cs_n <= 1'b1;
        dev_read <= 1'b0;
        acc_on_reg <= 1'b0;
        state_reg <= acc_next;
        if (state_reg == DD_HB) begin
          cdb_idx_reg <= cdb_idx_reg + 3'h1;
        end
        settle_reg <= 8'h00;
      end else begin
        acc_cnt_reg <= acc_cnt_reg + 8'h01;
      end
    end else begin
      case (state_reg)
        DD_IDLE: begin
          cdb_idx_reg <= 3'h0;
          if (start_req) begin
            state_reg <= pwdata[`DD_CTRL_HD] ? DD_BLO : DD_GPO;
          end
        end
        DD_GPO: begin
          state_reg <= DD_BLO;
        end
        DD_WAIT: begin
          // Hard disk commands need no separate seek first
          if (settle_reg != 8'(SETTLE_CYC)) begin
            settle_reg <= settle_reg + 8'h01;
          end else if (!active_s) begin
            if (ctl_hd_reg) begin
              state_reg <= DD_HSTAT;
            end else if (count_reg > 8'h01 && !ctl_track_reg) begin
              state_reg <= DD_FINT;
            end else begin
              state_reg <= DD_STAT;
            end
          end
        end
        default: begin
          state_reg <= DD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Drive and side select port
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpo_side_sel <= 1'b1;
      gpo_drive0_sel_n <= 1'b1;
      gpo_drive1_sel_n <= 1'b1;
    end else if (state_reg == DD_GPO) begin
      gpo_drive0_sel_n <= ctl_drive_reg;
      gpo_drive1_sel_n <= !ctl_drive_reg;
      gpo_side_sel <= ctl_side_reg;
    end
  end

  // ----------------------------------------
  // Result capture and done flag
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_stat_reg <= 8'h00;
      hd_stat_reg <= 8'h00;
      ecc_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (state_reg == DD_DONE) begin
        done_reg <= 1'b1;
      end else if (done_clr) begin
        done_reg <= 1'b0;
      end
      if (start_req) begin
        ecc_reg <= 1'b0;
      end
      if (acc_on_reg && acc_cnt_reg == 8'(STROBE_CYC + 2)) begin
        if (state_reg == DD_STAT) begin
          dma_stat_reg <= active_rdata;
        end
        if (state_reg == DD_HSTAT) begin
          hd_stat_reg <= active_rdata;
          ecc_reg <= active_rdata != 8'h00 &&
                     (cdb_op_reg == `DD_OP_VERIFY ||
                      cdb_op_reg == `DD_OP_READ);
        end
      end
    end
  end

  // Opcode kept from byte 0 as it is sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdb_op_reg <= `DD_OP_TEST;
    end else if (state_reg == DD_HB && cdb_idx_reg == 3'h0) begin
      cdb_op_reg <= {3'b000, cdb_byte[4:0]};
    end
  end

endmodule

`default_nettype wire

// file: src/dd_pkg.sv
`default_nettype none

package dd_pkg;

  typedef enum logic [4:0] {
    DD_IDLE, DD_GPO, DD_BLO, DD_BMI, DD_BHI, DD_TOG, DD_DIR, DD_SCNT,
    DD_LCNT, DD_SCMD, DD_FCMD, DD_HB, DD_FLAG, DD_REL, DD_WAIT,
    DD_FINT, DD_HSTAT, DD_STAT, DD_DONE
  } dd_state_t;

endpackage

`default_nettype wire

// file: src/dd_sync.sv
`default_nettype none

module dd_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: testbench/dd_dev_model.sv
`include "dd_cfg.svh"
`default_nettype none

module dd_dev_model #(
  parameter int SECT_CYC = 16,
  parameter logic [7:0] DONE_ST = 8'h05
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic dev_cs_n,
  input wire logic dev_read,
  input wire logic [7:0] hd_status,
  output logic [7:0] dev_rdata,
  output logic dev_active
);
  // No media change output exists
  logic cs_q;
  logic [15:0] mode_reg;
  logic [23:0] base_reg;
  logic [7:0] scnt_reg;
  logic [7:0] st_reg;
  logic [7:0] junk_reg;
  int byte_cnt;
  // Unselected bus toggles so stale data never looks valid
  assign dev_rdata = (!dev_cs_n && dev_read) ?
    (dev_addr == `DD_DEV_STATUS ? st_reg : hd_status) : junk_reg;
  assign dev_active = (scnt_reg != 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= 1'b1;
      mode_reg <= '0;
      base_reg <= '0;
      scnt_reg <= '0;
      st_reg <= '0;
      junk_reg <= 8'h5A;
      byte_cnt <= 0;
    end else begin
      cs_q <= dev_cs_n;
      junk_reg <= ~junk_reg;
      if (scnt_reg != 8'h00) begin
        base_reg <= base_reg + 24'd1;
        byte_cnt <= (byte_cnt == SECT_CYC - 1) ? 0 : byte_cnt + 1;
        if (byte_cnt == SECT_CYC - 1) begin
          scnt_reg <= scnt_reg - 8'h01;
          if (scnt_reg == 8'h01) st_reg <= DONE_ST;
        end
      end
      if (cs_q && !dev_cs_n && !dev_read) begin
        case (dev_addr)
          `DD_DEV_MODE: begin
            if (dev_wdata[`DD_MODE_DIR] != mode_reg[`DD_MODE_DIR]) begin
              st_reg <= 8'h00;
            end
            mode_reg <= dev_wdata;
          end
          `DD_DEV_DATA: begin
            if (mode_reg[`DD_MODE_SCNT]) begin
              scnt_reg <= dev_wdata[7:0];
              byte_cnt <= 0;
            end
          end
          `DD_DEV_BASE_LO: base_reg[7:0] <= dev_wdata[7:0];
          `DD_DEV_BASE_MI: base_reg[15:8] <= dev_wdata[7:0];
          `DD_DEV_BASE_HI: base_reg[23:16] <= dev_wdata[7:0];
          default: ;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// file: testbench/dd_host_checker.sv
`include "dd_cfg.svh"
`default_nettype none

module dd_host_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic dev_cs_n,
  input wire logic dev_read,
  input wire logic dev_active,
  input wire logic gpo_side_sel,
  input wire logic gpo_drive0_sel_n,
  input wire logic gpo_drive1_sel_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cs_q;
  logic [15:0] mode_reg;
  logic [2:0] last_reg;
  logic [2:0] cdb_reg;
  logic go;
  logic wr_go;
  logic hd_cmd;
  assign go = cs_q && !dev_cs_n;
  assign wr_go = go && !dev_read;
  assign hd_cmd = mode_reg[`DD_MODE_HD] && mode_reg[`DD_MODE_CMD];
  // ----------------------------------------
  // Device write tracker
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= 1'b1;
      mode_reg <= '0;
      last_reg <= '0;
      cdb_reg <= '0;
    end else begin
      cs_q <= dev_cs_n;
      if (wr_go) begin
        last_reg <= dev_addr;
        if (dev_addr == `DD_DEV_MODE) begin
          mode_reg <= dev_wdata;
          if (!dev_wdata[`DD_MODE_CMD]) cdb_reg <= '0;
        end
        if (dev_addr == `DD_DEV_DATA && hd_cmd) cdb_reg <= cdb_reg + 3'd1;
      end
    end
  end
  sequence s_held;
    (!dev_cs_n && $stable(dev_addr) && $stable(dev_wdata)
      && $stable(dev_read))[*8];
  endsequence
  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("no answer after setup");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("ready held too long");
  property p_unmapped;
    pready && paddr > 8'h1C |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_reset_gpo;
    $rose(presetn) |-> gpo_side_sel && gpo_drive0_sel_n && gpo_drive1_sel_n;
  endproperty
  a_reset_gpo: assert property (p_reset_gpo)
    else $error("drive outputs wrong after reset");
  property p_strobe;
    $fell(dev_cs_n) |=> s_held ##1 dev_cs_n;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("device strobe length or hold wrong");
  property p_gap;
    dev_cs_n |-> !dev_read;
  endproperty
  a_gap: assert property (p_gap)
    else $error("read line high outside a strobe");
  property p_flag;
    wr_go && dev_addr == `DD_DEV_DATA && hd_cmd
      |-> mode_reg[`DD_MODE_FLAG] == (cdb_reg != 3'd0);
  endproperty
  a_flag: assert property (p_flag)
    else $error("command flag wrong for command byte");
  property p_cdb_len;
    wr_go && dev_addr == `DD_DEV_MODE && !dev_wdata[`DD_MODE_CMD] && hd_cmd
      |-> cdb_reg == 3'd6;
  endproperty
  a_cdb_len: assert property (p_cdb_len)
    else $error("command block not six bytes");
  property p_no_poll;
    go && dev_read && dev_addr == `DD_DEV_STATUS |-> !dev_active;
  endproperty
  a_no_poll: assert property (p_no_poll)
    else $error("status read while transfer active");
  property p_base_order;
    wr_go && (dev_addr == `DD_DEV_BASE_MI || dev_addr == `DD_DEV_BASE_HI)
      |-> last_reg == dev_addr + 3'd1;
  endproperty
  a_base_order: assert property (p_base_order)
    else $error("base address bytes out of order");
  property p_trigger;
    wr_go && dev_addr == `DD_DEV_DATA && mode_reg[`DD_MODE_SCNT]
      |-> last_reg == `DD_DEV_MODE;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("count written without selecting it first");
endmodule

bind dd_host dd_host_checker u_dd_host_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_cs_n(dev_cs_n),
  .dev_read(dev_read), .dev_active(dev_active),
  .gpo_side_sel(gpo_side_sel), .gpo_drive0_sel_n(gpo_drive0_sel_n),
  .gpo_drive1_sel_n(gpo_drive1_sel_n)
);

`default_nettype wire

// file: testbench/tb_top.sv
`include "dd_cfg.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DONE_ST = 8'h05;
  localparam logic [7:0] HD_ST = 8'h02;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] hd_status = HD_ST;
  logic [31:0] prdata;
  logic pready, pslverr, dev_cs_n, dev_read, dev_active, gpo_side_sel;
  logic gpo_drive0_sel_n, gpo_drive1_sel_n;
  logic [2:0] dev_addr;
  logic [15:0] dev_wdata;
  logic [7:0] dev_rdata;
  logic cs_q = 1'b1;
  logic [35:0] exp_q[$];
  logic [19:0] got_q[$];
  int fails = 0;
  int num_checks = 0;
  always #5 pclk = ~pclk;
  dd_host u_dd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_cs_n(dev_cs_n),
    .dev_read(dev_read), .dev_rdata(dev_rdata), .dev_active(dev_active),
    .gpo_side_sel(gpo_side_sel), .gpo_drive0_sel_n(gpo_drive0_sel_n),
    .gpo_drive1_sel_n(gpo_drive1_sel_n));
  dd_dev_model #(.SECT_CYC(16), .DONE_ST(DONE_ST)) u_dd_dev_model (
    .pclk(pclk), .presetn(presetn), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_cs_n(dev_cs_n), .dev_read(dev_read),
    .hd_status(hd_status), .dev_rdata(dev_rdata), .dev_active(dev_active));
  // ----------------------------------------
  // Device access monitor and tasks
  // ----------------------------------------
  always @(posedge pclk) begin
    cs_q <= dev_cs_n;
    if (cs_q && !dev_cs_n) got_q.push_back({dev_read, dev_addr, dev_wdata});
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic ex(input logic rd, input logic [2:0] a,
                    input logic [15:0] d, m);
    exp_q.push_back({m, rd, a, d});
  endtask
  task automatic run(input logic hd, dir, drv, trk, input logic [7:0] cnt, op);
    logic [31:0] r, xs, msk;
    logic e;
    logic [15:0] dm, mm;
    logic [7:0] cdb[6];
    int n;
    cdb = '{op, 8'h21, 8'h34, 8'h56, cnt, 8'h00};
    dm = {7'h00, dir, 8'h00};
    mm = hd ? 16'h0118 : 16'h0198;
    exp_q.delete();
    got_q.delete();
    ex(1'b0, `DD_DEV_BASE_LO, 16'h0056, 16'h00FF);
    ex(1'b0, `DD_DEV_BASE_MI, 16'h0034, 16'h00FF);
    ex(1'b0, `DD_DEV_BASE_HI, 16'h0012, 16'h00FF);
    ex(1'b0, `DD_DEV_MODE, dm ^ 16'h0100, mm);
    ex(1'b0, `DD_DEV_MODE, dm, mm);
    ex(1'b0, `DD_DEV_MODE, dm | 16'h0010, mm);
    ex(1'b0, `DD_DEV_DATA, {8'h00, cnt}, 16'h00FF);
    if (!hd) begin
      ex(1'b0, `DD_DEV_MODE, dm | 16'h0008, mm);
      ex(1'b0, `DD_DEV_DATA, 16'h00A4, 16'h00FF);
      if (cnt > 8'h01 && !trk) ex(1'b0, 3'h0, 16'h00D0, 16'h00FF);
    end else begin
      ex(1'b0, `DD_DEV_MODE, dm | 16'h0088, 16'h019A);
      for (n = 0; n < 6; n++) begin
        if (n == 1) ex(1'b0, `DD_DEV_MODE, dm | 16'h008A, 16'h019A);
        ex(1'b0, `DD_DEV_DATA, {8'h00, cdb[n]}, 16'h00FF);
      end
      ex(1'b0, `DD_DEV_MODE, dm | 16'h0080, 16'h019A);
      ex(1'b1, `DD_DEV_DATA, 16'h0000, 16'h0000);
    end
    ex(1'b1, `DD_DEV_STATUS, 16'h0000, 16'h0000);
    wr(`DD_OFS_ADDR, 32'h00123456);
    wr(`DD_OFS_COUNT, {24'h0, cnt});
    wr(`DD_OFS_FCMD, 32'h0000D0A4);
    wr(`DD_OFS_CDB_LO, {cdb[3], cdb[2], cdb[1], cdb[0]});
    wr(`DD_OFS_CDB_HI, {16'h0000, cdb[5], cdb[4]});
    apb(1'b0, `DD_OFS_LEN, 32'h0, r, e);
    chk("length", {15'h0000, cnt, 9'h000}, r);
    wr(`DD_OFS_CTRL, {26'h0, trk, drv, drv, hd, dir, 1'b1});
    n = 0;
    do begin
      apb(1'b0, `DD_OFS_STATUS, 32'h0, r, e);
      n++;
    end while (r[1] !== 1'b1 && n < 300);
    msk = hd ? 32'h00FFFFFF : 32'h0000FFFF;
    xs = {8'h00, HD_ST, DONE_ST, 5'h00,
          hd && (op == 8'h05 || op == 8'h08), 2'b10};
    for (n = 0; n < 2; n++) begin
      if (n == 1) apb(1'b0, `DD_OFS_STATUS, 32'h0, r, e);
      chk("status", xs & msk, r & msk);
    end
    chk("access count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) begin
      if (i < got_q.size()) begin
        chk("device access", {12'h0, exp_q[i][19:16],
            exp_q[i][15:0] & exp_q[i][35:20]}, {12'h0, got_q[i][19:16],
            got_q[i][15:0] & exp_q[i][35:20]});
      end
    end
    if (!hd) begin
      chk("drive selects", {29'h0, drv, !drv, drv}, {29'h0, gpo_side_sel,
          gpo_drive1_sel_n, gpo_drive0_sel_n});
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] ops[9];
    ops = '{8'h00, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h15, 8'h1A};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset selects", 32'h7, {29'h0, gpo_side_sel, gpo_drive0_sel_n,
        gpo_drive1_sel_n});
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    run(1'b0, 1'b1, 1'b1, 1'b0, 8'h02, 8'h00);
    run(1'b0, 1'b0, 1'b0, 1'b1, 8'h03, 8'h00);
    run(1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 8'h00);
    foreach (ops[i]) run(1'b1, ops[i][1], 1'b0, 1'b0, 8'h01 + ops[i][0],
                         ops[i]);
    summarize;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("unexpected run length: expected end, seen timeout");
    summarize;
  end
endmodule

`default_nettype wire
